// ### design/rovi_consts.svh
// register map, field positions and reset values of the over-voltage status block
// assumes an 8-bit register port and one 200 MHz clock
`ifndef ROVI_CONSTS_SVH
`define ROVI_CONSTS_SVH

// ********************************************************
// register port
// ********************************************************
`define ROVI_ADDR_W              8
`define ROVI_DATA_W              8
`define ROVI_ADDR_STATUS_UPPER   8'h00
`define ROVI_ADDR_SYSCTRL_LOWER  8'h01
`define ROVI_ADDR_IRQ_ENABLE     8'h02
`define ROVI_ADDR_FLAG_CLEAR     8'h03
`define ROVI_READ_UNMAPPED       8'h00

// ********************************************************
// field positions
// ********************************************************
`define ROVI_NUM_EVENTS          2
// flag, enable and clear bits share one layout
`define ROVI_BIT_OVERPOWER       0
`define ROVI_BIT_OVERVOLTAGE     1
// live comparator levels in the status register
`define ROVI_BIT_CMP_OVERPOWER   2
`define ROVI_BIT_CMP_OVERVOLTAGE 3
// system control lower register
`define ROVI_BIT_AUTO_CLEAR      0
`define ROVI_BIT_SHUTDOWN_SEL    1
`define ROVI_BIT_CONVERTER_EN    2

// ********************************************************
// reset values
// ********************************************************
`define ROVI_RST_AUTO_CLEAR      1'b0
`define ROVI_RST_SHUTDOWN_SEL    1'b0
`define ROVI_RST_CONVERTER_EN    1'b1
`define ROVI_RST_IRQ_ENABLE      2'h0
`define ROVI_RST_LDO_EN          1'b1

// over-power trip level of the external comparator, for reference
`define ROVI_OVERPOWER_TRIP_MV   18000

`endif

// ### design/rovi_pkg.sv
// types shared by the over-voltage status block
// assumes the constants header is on the include path
package rovi_pkg;
  `include "rovi_consts.svh"

  // ********************************************************
  // top-level state
  // ********************************************************
  typedef struct packed {
    logic                          cmp_ovpw_prev;
    logic                          auto_clear;
    logic                          shutdown_sel;
    logic                          converter_en;
    logic [`ROVI_NUM_EVENTS-1:0]   irq_enable;
    logic [`ROVI_DATA_W-1:0]       rdata;
    logic                          tune_oe;
    logic                          clamp;
    logic                          ldo_en;
  } rovi_state_t;
endpackage

// ### design/rovi_sync.sv
// two-flop synchroniser for asynchronous comparator levels
// assumes the inputs come from analog comparators with no clock
`timescale 1ns/1ps
module rovi_sync #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  // levels
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } rovi_sync_state_t;

  rovi_sync_state_t s_q;
  rovi_sync_state_t s_d;

  // meta is read by the second stage only
  always_comb begin
    s_d.meta   = i_async;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_sync = s_q.stable;
endmodule // rovi_sync

// ### design/rovi_flag.sv
// one sticky event flag: set by hardware, cleared by software
// assumes set and clear come from logic on the same clock
`timescale 1ns/1ps
module rovi_flag (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // control
  input  wire logic i_set,
  input  wire logic i_clear,
  output logic      o_flag
);
  typedef struct packed {
    logic flag;
  } rovi_flag_state_t;

  rovi_flag_state_t s_q;
  rovi_flag_state_t s_d;

  // an event in the clearing cycle must not be lost, so set wins
  always_comb begin
    s_d = s_q;
    if (i_set) begin
      s_d.flag = 1'b1;
    end else if (i_clear) begin
      s_d.flag = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_flag = s_q.flag;
endmodule // rovi_flag

// ### design/rovi_irq_top.sv
// rectifier over-power and over-voltage status, interrupt and protection outputs
// assumes comparators with hysteresis outside, a host register port on I_CLOCK,
// and open-drain pads resolved outside from the _O and _OE pairs
//
// How it works
// - overpower comparator turns on both tune switches
// - overpower flag set on comparator rising edge
// - tune switches low while overpower comparator high
// - enabled overpower flag pulls interrupt low
// - auto clear: status read clears overpower flag
// - writing overpower clear bit clears flag
// - interrupt released once enabled flags clear
// - overpower flag re-sets only after new rise
// - overvoltage comparator clamps both antenna inputs
// - clamps released when overvoltage comparator falls
// - overvoltage flag set while comparator high
// - enabled overvoltage flag pulls interrupt low
// - writing overvoltage clear bit clears flag
// - auto clear: status read clears overvoltage flag
// - LDO enable never dropped by protection
// - shutdown select resets zero, converter untouched
// - select, enable and flag force converter off
`timescale 1ns/1ps
`include "rovi_consts.svh"
module rovi_irq_top (
  // clock and reset
  input  wire logic                    I_CLOCK,
  input  wire logic                    I_RST_N,
  // register port
  input  wire logic [`ROVI_ADDR_W-1:0] I_ADDR,
  input  wire logic [`ROVI_DATA_W-1:0] I_WDATA,
  input  wire logic                    I_WR,
  input  wire logic                    I_RD,
  output logic      [`ROVI_DATA_W-1:0] O_RDATA,
  // comparator levels, asynchronous
  input  wire logic                    I_OVERPOWER_CMP,
  input  wire logic                    I_OVERVOLTAGE_CMP,
  // tune switch open-drain pins
  output logic                         O_TUNE_SWITCH_A_O,
  output logic                         O_TUNE_SWITCH_A_OE,
  output logic                         O_TUNE_SWITCH_B_O,
  output logic                         O_TUNE_SWITCH_B_OE,
  // antenna input clamps
  output logic                         O_ANTENNA_IN_A_CLAMP,
  output logic                         O_ANTENNA_IN_B_CLAMP,
  // interrupt open-drain pin, active low
  output logic                         O_INT_N_O,
  output logic                         O_INT_N_OE,
  // supply enables
  output logic                         O_CONVERTER_ENABLE,
  output logic                         O_LDO_ENABLE
);
  localparam int NEV = `ROVI_NUM_EVENTS;
  localparam int OP  = `ROVI_BIT_OVERPOWER;
  localparam int OV  = `ROVI_BIT_OVERVOLTAGE;

  // ********************************************************
  // address decode
  // ********************************************************
  function automatic logic hit(input logic [`ROVI_ADDR_W-1:0] addr,
                               input logic [`ROVI_ADDR_W-1:0] target);
    hit = (addr == target);
  endfunction

  rovi_pkg::rovi_state_t s_q;
  rovi_pkg::rovi_state_t s_d;

  logic [NEV-1:0] cmp_s;
  logic [NEV-1:0] flag_set;
  logic [NEV-1:0] flag_clr;
  logic [NEV-1:0] flags;
  logic           ovpw_rise;
  logic           wr_ctrl;
  logic           wr_enable;
  logic           wr_clear;
  logic           wr_status;
  logic           rd_status;
  logic           auto_rd;
  logic           force_off;

  // ********************************************************
  // comparator inputs
  // ********************************************************
  // two-flop synchronisers
  rovi_sync #(
    .WIDTH (NEV)
  ) u_sync (
    .i_clk   (I_CLOCK),
    .i_rst_n (I_RST_N),
    .i_async ({I_OVERVOLTAGE_CMP, I_OVERPOWER_CMP}),
    .o_sync  (cmp_s)
  );

  // only a fresh rise can set it again
  assign ovpw_rise = cmp_s[OP] & ~s_q.cmp_ovpw_prev;

  // ********************************************************
  // strobes
  // ********************************************************
  assign wr_ctrl   = I_WR && hit(I_ADDR, `ROVI_ADDR_SYSCTRL_LOWER);
  assign wr_enable = I_WR && hit(I_ADDR, `ROVI_ADDR_IRQ_ENABLE);
  assign wr_clear  = I_WR && hit(I_ADDR, `ROVI_ADDR_FLAG_CLEAR);
  assign wr_status = I_WR && hit(I_ADDR, `ROVI_ADDR_STATUS_UPPER);
  assign rd_status = I_RD && hit(I_ADDR, `ROVI_ADDR_STATUS_UPPER);
  assign auto_rd   = rd_status && s_q.auto_clear;

  // ********************************************************
  // event flags
  // ********************************************************
  always_comb begin
    flag_set     = '0;
    flag_set[OP] = ovpw_rise;
    flag_set[OV] = cmp_s[OV];
    flag_clr     = '0;
    if (wr_clear || wr_status) begin
      flag_clr = I_WDATA[NEV-1:0];
    end
    if (auto_rd) begin
      flag_clr = '1;
    end
  end

  generate
    for (genvar i = 0; i < NEV; i++) begin : g_flag
      rovi_flag u_flag (
        .i_clk   (I_CLOCK),
        .i_rst_n (I_RST_N),
        .i_set   (flag_set[i]),
        .i_clear (flag_clr[i]),
        .o_flag  (flags[i])
      );
    end
  endgenerate

  assign force_off = s_q.shutdown_sel && s_q.irq_enable[OV] && flags[OV];

  // ********************************************************
  // next state
  // ********************************************************
  always_comb begin
    s_d               = s_q;
    s_d.cmp_ovpw_prev = cmp_s[OP];
    s_d.tune_oe       = cmp_s[OP];
    s_d.clamp         = cmp_s[OV];
    s_d.ldo_en        = `ROVI_RST_LDO_EN;
    if (wr_ctrl) begin
      s_d.auto_clear   = I_WDATA[`ROVI_BIT_AUTO_CLEAR];
      s_d.shutdown_sel = I_WDATA[`ROVI_BIT_SHUTDOWN_SEL];
      // host turns the converter back on
      s_d.converter_en = I_WDATA[`ROVI_BIT_CONVERTER_EN];
    end
    if (wr_enable) begin
      s_d.irq_enable = I_WDATA[NEV-1:0];
    end
    // hardware only ever turns it off
    if (force_off) begin
      s_d.converter_en = 1'b0;
    end
    // read data stand for one cycle only
    s_d.rdata = '0;
    if (I_RD) begin
      case (I_ADDR)
        `ROVI_ADDR_STATUS_UPPER: begin
          s_d.rdata[NEV-1:0]                 = flags;
          s_d.rdata[`ROVI_BIT_CMP_OVERPOWER]   = cmp_s[OP];
          s_d.rdata[`ROVI_BIT_CMP_OVERVOLTAGE] = cmp_s[OV];
        end
        `ROVI_ADDR_SYSCTRL_LOWER: begin
          s_d.rdata[`ROVI_BIT_AUTO_CLEAR]   = s_q.auto_clear;
          s_d.rdata[`ROVI_BIT_SHUTDOWN_SEL] = s_q.shutdown_sel;
          s_d.rdata[`ROVI_BIT_CONVERTER_EN] = s_q.converter_en;
        end
        `ROVI_ADDR_IRQ_ENABLE: begin
          s_d.rdata[NEV-1:0] = s_q.irq_enable;
        end
        // clear register is write-only
        default: begin
          s_d.rdata = `ROVI_READ_UNMAPPED;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      s_q.cmp_ovpw_prev <= 1'b0;
      s_q.auto_clear    <= `ROVI_RST_AUTO_CLEAR;
      s_q.shutdown_sel  <= `ROVI_RST_SHUTDOWN_SEL;
      s_q.converter_en  <= `ROVI_RST_CONVERTER_EN;
      s_q.irq_enable    <= `ROVI_RST_IRQ_ENABLE;
      s_q.rdata         <= '0;
      s_q.tune_oe       <= 1'b0;
      s_q.clamp         <= 1'b0;
      s_q.ldo_en        <= `ROVI_RST_LDO_EN;
    end else begin
      s_q <= s_d;
    end
  end

  // ********************************************************
  // outputs
  // ********************************************************
  assign O_RDATA              = s_q.rdata;
  // open-drain pins only ever drive low
  assign O_TUNE_SWITCH_A_O    = 1'b0;
  assign O_TUNE_SWITCH_B_O    = 1'b0;
  assign O_TUNE_SWITCH_A_OE   = s_q.tune_oe;
  assign O_TUNE_SWITCH_B_OE   = s_q.tune_oe;
  assign O_ANTENNA_IN_A_CLAMP = s_q.clamp;
  assign O_ANTENNA_IN_B_CLAMP = s_q.clamp;
  assign O_INT_N_O            = 1'b0;
  assign O_INT_N_OE           = |(flags & s_q.irq_enable);
  assign O_CONVERTER_ENABLE   = s_q.converter_en;
  assign O_LDO_ENABLE         = s_q.ldo_en;

  // ********************************************************
  // checks
  // ********************************************************
  AST_TUNE_ON: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    cmp_s[OP] |=> O_TUNE_SWITCH_A_OE && O_TUNE_SWITCH_B_OE)
    else $error("tune switches not pulled low during overpower");

  AST_TUNE_HOLD: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    cmp_s[OP] [*3] |-> (O_TUNE_SWITCH_A_OE && O_TUNE_SWITCH_B_OE) [*2])
    else $error("tune switch released while comparator high");

  AST_TUNE_OFF: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    !cmp_s[OP] |=> !O_TUNE_SWITCH_A_OE && !O_TUNE_SWITCH_B_OE)
    else $error("tune switch held after comparator fell");

  AST_OVPW_SET: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    $rose(cmp_s[OP]) |=> flags[OP])
    else $error("overpower flag missed a rising edge");

  AST_OVPW_INT: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    $rose(cmp_s[OP]) && s_q.irq_enable[OP] && !wr_enable |=> O_INT_N_OE && !O_INT_N_O)
    else $error("enabled overpower event did not pull interrupt low");

  AST_OVPW_AUTO: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    rd_status && s_q.auto_clear && !ovpw_rise |=> !flags[OP])
    else $error("status read did not clear overpower flag");

  AST_OVPW_W1C: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    wr_clear && I_WDATA[OP] && !ovpw_rise |=> !flags[OP])
    else $error("clear write did not clear overpower flag");

  AST_INT_RELEASE: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    ((flags & s_q.irq_enable) != '0) && ((flags & s_q.irq_enable & ~flag_clr) == '0) &&
    ((flag_set & s_q.irq_enable) == '0) && !wr_enable |=> !O_INT_N_OE)
    else $error("interrupt held with no enabled flag");

  AST_OVPW_NO_RESET: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    !flags[OP] && cmp_s[OP] && s_q.cmp_ovpw_prev |=> !flags[OP])
    else $error("overpower flag set again without a new rise");

  AST_CLAMP_ON: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    cmp_s[OV] |=> O_ANTENNA_IN_A_CLAMP && O_ANTENNA_IN_B_CLAMP)
    else $error("antenna inputs not clamped in overvoltage");

  AST_CLAMP_OFF: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    $fell(cmp_s[OV]) |=> !O_ANTENNA_IN_A_CLAMP && !O_ANTENNA_IN_B_CLAMP)
    else $error("antenna clamp not released");

  AST_OVV_SET: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    cmp_s[OV] |=> flags[OV])
    else $error("overvoltage flag not set while comparator high");

  AST_OVV_INT: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    cmp_s[OV] && s_q.irq_enable[OV] && !wr_enable |=> O_INT_N_OE && !O_INT_N_O)
    else $error("enabled overvoltage flag did not pull interrupt low");

  AST_OVV_W1C: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    wr_clear && I_WDATA[OV] && !cmp_s[OV] |=> !flags[OV])
    else $error("clear write did not clear overvoltage flag");

  AST_OVV_AUTO: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    auto_rd && !cmp_s[OV] |=> !flags[OV])
    else $error("status read did not clear overvoltage flag");

  AST_LDO_ON: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    cmp_s[OV] |=> O_LDO_ENABLE [*3])
    else $error("LDO enable dropped in overvoltage");

  AST_DC_UNTOUCHED: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    !s_q.shutdown_sel && !wr_ctrl |=> $stable(O_CONVERTER_ENABLE))
    else $error("converter enable changed with shutdown select off");

  AST_DC_FORCE: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    s_q.shutdown_sel && s_q.irq_enable[OV] && $rose(flags[OV]) |=> !O_CONVERTER_ENABLE)
    else $error("converter not shut down on overvoltage");

  AST_SYNC_DELAY: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    $rose(I_OVERVOLTAGE_CMP) ##1 I_OVERVOLTAGE_CMP [*2] |-> cmp_s[OV])
    else $error("comparator not seen after two stages");

  AST_SYNC_OVPW: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    $rose(I_OVERPOWER_CMP) ##1 I_OVERPOWER_CMP [*2] |-> cmp_s[OP])
    else $error("overpower comparator not seen after two stages");

  AST_OVPW_HELD: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    flags[OP] && !flag_clr[OP] |=> flags[OP])
    else $error("overpower flag dropped without a clear");

  AST_OVV_HELD: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    flags[OV] && !flag_clr[OV] |=> flags[OV])
    else $error("overvoltage flag dropped without a clear");

  AST_OVPW_NO_SPURIOUS: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    !flags[OP] && !cmp_s[OP] |=> !flags[OP])
    else $error("overpower flag set with comparator low");

  AST_OVV_NO_SPURIOUS: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    !flags[OV] && !cmp_s[OV] |=> !flags[OV])
    else $error("overvoltage flag set with comparator low");

  AST_OVPW_RDATA: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    rd_status |=> O_RDATA[OP] == $past(flags[OP]))
    else $error("status read lost the overpower flag");

  AST_OVV_RDATA: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    rd_status |=> O_RDATA[OV] == $past(flags[OV]))
    else $error("status read lost the overvoltage flag");

  AST_DC_KEEP_FORCED: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    force_off |=> !O_CONVERTER_ENABLE)
    else $error("converter enabled while shutdown is forced");

  AST_DC_HOST_ON: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    wr_ctrl && I_WDATA[`ROVI_BIT_CONVERTER_EN] && !force_off |=> O_CONVERTER_ENABLE)
    else $error("host could not re-enable the converter");

  AST_DC_NO_WAKE: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    !wr_ctrl && !O_CONVERTER_ENABLE |=> !O_CONVERTER_ENABLE)
    else $error("converter turned on without a host write");
endmodule // rovi_irq_top

// ### bench/rovi_rect_model.sv
// behavioural rectifier front end: turns a rectified voltage in millivolts
// into the two over-power and over-voltage comparator levels, with hysteresis
// assumes the bench moves the voltage just after a rising clock edge
`timescale 1ns/1ps
`include "rovi_consts.svh"
module rovi_rect_model #(
  parameter int OVERPOWER_TRIP_MV      = `ROVI_OVERPOWER_TRIP_MV,
  parameter int OVERPOWER_RELEASE_MV   = 17000,
  parameter int OVERVOLTAGE_TRIP_MV    = 20000,
  parameter int OVERVOLTAGE_RELEASE_MV = 19000
) (
  // rectified voltage
  input  wire logic [15:0] i_rect_mv,
  // comparator levels
  output logic             o_overpower_cmp,
  output logic             o_overvoltage_cmp
);
  // ********************************************************
  // comparators
  // ********************************************************
  initial begin
    o_overpower_cmp   = 1'b0;
    o_overvoltage_cmp = 1'b0;
  end

  // levels between trip and release keep the last state, as real hysteresis does
  always @(i_rect_mv) begin
    if (int'(i_rect_mv) > OVERPOWER_TRIP_MV) o_overpower_cmp = 1'b1;
    else if (int'(i_rect_mv) < OVERPOWER_RELEASE_MV) o_overpower_cmp = 1'b0;
    if (int'(i_rect_mv) > OVERVOLTAGE_TRIP_MV) o_overvoltage_cmp = 1'b1;
    else if (int'(i_rect_mv) < OVERVOLTAGE_RELEASE_MV) o_overvoltage_cmp = 1'b0;
  end
endmodule // rovi_rect_model

// ### bench/tb_rectifier_overvoltage_irq.sv
// self-checking bench of the over-power / over-voltage status block
// assumes the register port answers reads one cycle later and never stalls
`timescale 1ns/1ps
`include "rovi_consts.svh"
module tb_rectifier_overvoltage_irq;
  // ********************************************************
  // signals
  // ********************************************************
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  rdata;
  logic [15:0] rect_mv = 16'h0000;
  logic        op_cmp, ov_cmp;
  logic        ta_o, ta_oe, tb_o, tb_oe, clamp_a, clamp_b;
  logic        int_o, int_oe, conv_en, ldo_en;
  wire         int_n = int_oe ? int_o : 1'b1;
  int          fail_count = 0;
  int          n_compared = 0;

  always #2.5 clk = ~clk;

  rovi_rect_model u_rect (.i_rect_mv(rect_mv), .o_overpower_cmp(op_cmp), .o_overvoltage_cmp(ov_cmp));

  rovi_irq_top u_dut (
    .I_CLOCK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .I_OVERPOWER_CMP(op_cmp), .I_OVERVOLTAGE_CMP(ov_cmp),
    .O_TUNE_SWITCH_A_O(ta_o), .O_TUNE_SWITCH_A_OE(ta_oe), .O_TUNE_SWITCH_B_O(tb_o),
    .O_TUNE_SWITCH_B_OE(tb_oe), .O_ANTENNA_IN_A_CLAMP(clamp_a), .O_ANTENNA_IN_B_CLAMP(clamp_b),
    .O_INT_N_O(int_o), .O_INT_N_OE(int_oe), .O_CONVERTER_ENABLE(conv_en), .O_LDO_ENABLE(ldo_en)
  );

  // ********************************************************
  // tasks
  // ********************************************************
  task automatic close_out;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk_reg(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_pin(input string name, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic reg_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk_reg(name, exp, rdata);
  endtask

  // comparator change takes three edges to reach the outputs; leave margin
  task automatic set_mv(input int mv);
    @(posedge clk);
    rect_mv <= 16'(mv);
    repeat (6) @(posedge clk);
    #1;
  endtask

  task automatic chk_pins(input logic tune, input logic clamp, input logic irq_n);
    chk_pin("tune_a_oe", tune, ta_oe);
    chk_pin("tune_b_oe", tune, tb_oe);
    chk_pin("tune_a_o", 1'b0, ta_o);
    chk_pin("tune_b_o", 1'b0, tb_o);
    chk_pin("clamp_a", clamp, clamp_a);
    chk_pin("clamp_b", clamp, clamp_b);
    chk_pin("int_n", irq_n, int_n);
    chk_pin("ldo_en", 1'b1, ldo_en);
  endtask

  // ********************************************************
  // tests
  // ********************************************************
  initial begin
    #100us;
    fail_count++;
    close_out();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    // reset values and unmapped space
    chk_pins(1'b0, 1'b0, 1'b1);
    chk_pin("conv_en", 1'b1, conv_en);
    reg_chk("status", `ROVI_ADDR_STATUS_UPPER, 8'h00);
    reg_chk("sysctl", `ROVI_ADDR_SYSCTRL_LOWER, 8'h04);
    reg_chk("irq_en", `ROVI_ADDR_IRQ_ENABLE, 8'h00);
    reg_chk("flag_clr", `ROVI_ADDR_FLAG_CLEAR, 8'h00);
    reg_wr(8'h55, 8'hff);
    reg_chk("unmapped", 8'h55, 8'h00);
    reg_chk("sysctl_kept", `ROVI_ADDR_SYSCTRL_LOWER, 8'h04);

    // over-power event, clear by write while still high
    reg_wr(`ROVI_ADDR_IRQ_ENABLE, 8'h01);
    set_mv(18500);
    chk_pins(1'b1, 1'b0, 1'b0);
    reg_chk("status_op", `ROVI_ADDR_STATUS_UPPER, 8'h05);
    reg_wr(`ROVI_ADDR_FLAG_CLEAR, 8'h01);
    #1;
    chk_pin("int_n_released", 1'b1, int_n);
    reg_chk("status_cleared", `ROVI_ADDR_STATUS_UPPER, 8'h04);
    set_mv(17500);
    chk_pins(1'b1, 1'b0, 1'b1);
    reg_chk("status_no_reset", `ROVI_ADDR_STATUS_UPPER, 8'h04);
    set_mv(16000);
    chk_pins(1'b0, 1'b0, 1'b1);
    set_mv(18500);
    reg_chk("status_rearmed", `ROVI_ADDR_STATUS_UPPER, 8'h05);
    reg_wr(`ROVI_ADDR_IRQ_ENABLE, 8'h00);
    #1;
    chk_pin("int_n_masked", 1'b1, int_n);
    set_mv(16000);
    reg_wr(`ROVI_ADDR_FLAG_CLEAR, 8'h01);

    // auto clear on read, both events, no converter shutdown
    reg_wr(`ROVI_ADDR_SYSCTRL_LOWER, 8'h05);
    reg_wr(`ROVI_ADDR_IRQ_ENABLE, 8'h02);
    set_mv(21000);
    chk_pins(1'b1, 1'b1, 1'b0);
    chk_pin("conv_kept", 1'b1, conv_en);
    set_mv(16000);
    chk_pins(1'b0, 1'b0, 1'b0);
    reg_chk("status_auto", `ROVI_ADDR_STATUS_UPPER, 8'h03);
    reg_chk("status_after", `ROVI_ADDR_STATUS_UPPER, 8'h00);
    chk_pin("int_n_auto", 1'b1, int_n);

    // converter shutdown, clear bit and host recovery
    reg_wr(`ROVI_ADDR_SYSCTRL_LOWER, 8'h06);
    set_mv(21000);
    chk_pin("conv_forced", 1'b0, conv_en);
    chk_pin("ldo_kept", 1'b1, ldo_en);
    reg_chk("sysctl_forced", `ROVI_ADDR_SYSCTRL_LOWER, 8'h02);
    set_mv(16000);
    reg_chk("status_ov", `ROVI_ADDR_STATUS_UPPER, 8'h03);
    reg_wr(`ROVI_ADDR_FLAG_CLEAR, 8'h02);
    reg_chk("status_ov_clr", `ROVI_ADDR_STATUS_UPPER, 8'h01);
    reg_wr(`ROVI_ADDR_SYSCTRL_LOWER, 8'h06);
    #1;
    chk_pin("conv_back", 1'b1, conv_en);
    reg_chk("sysctl_back", `ROVI_ADDR_SYSCTRL_LOWER, 8'h06);
    // a one written to the status register clears too
    reg_wr(`ROVI_ADDR_STATUS_UPPER, 8'h01);
    reg_chk("status_wr_clr", `ROVI_ADDR_STATUS_UPPER, 8'h00);
    chk_pin("int_n_end", 1'b1, int_n);

    // mid-run reset brings back the defaults
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    reg_chk("sysctl_rst", `ROVI_ADDR_SYSCTRL_LOWER, 8'h04);
    reg_chk("irq_en_rst", `ROVI_ADDR_IRQ_ENABLE, 8'h00);
    chk_pin("conv_rst", 1'b1, conv_en);
    chk_pins(1'b0, 1'b0, 1'b1);
    close_out();
  end
endmodule // tb_rectifier_overvoltage_irq
